// >>> rtl/multi_mode_timer_unit.sv
// Multi-mode timer unit: group A and group B channels behind an AXI4-Lite slave
module multi_mode_timer_unit import timer_unit_pkg::*; #(
  parameter int NUM_A = 5,
  parameter int NUM_B = 6
) (
  input wire logic aclk, // 20 MHz clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [7:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [7:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic [NUM_A-1:0] group_a_trigger_pin, // Group A trigger / event pins
  input wire logic [NUM_B-1:0] group_b_input_pin, // Group B event / measured pins
  input wire logic nmi_n, // Emergency cutoff pin, active low
  output logic [NUM_A-1:0] group_a_output_pin, // Group A output levels
  output logic [NUM_A-1:0] group_a_output_oe_n, // Low while the output pin is driven
  output logic [NUM_A-1:0] group_a_int_request, // Group A request flags
  output logic [NUM_B-1:0] group_b_int_request // Group B request flags
);
  localparam int NUM_CH = NUM_A + NUM_B;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [7:0] src_mask(input logic [1:0] sel);
    case (sel)
      2'b00: src_mask = 8'h00;
      2'b01: src_mask = PRE_MASK_DIV8;
      2'b10: src_mask = PRE_MASK_DIV32;
      default: src_mask = PRE_MASK_DIV256;
    endcase
  endfunction : src_mask

  logic aw_held, w_held, wr_fire, wr_ok, rd_fire, rd_ok;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [15:0] rd_val;
  logic [7:0] start_one, start_two, pre;
  logic cutoff_enable, cutoff;
  logic [NUM_A-1:0] a_dir, a_run, a_run_d, a_set, a_reload_now, a_ovf_now, a_out_q, sw_trig;
  logic [NUM_B-1:0] b_run, b_run_d, b_set, b_reload_now, b_ovf, b_seen, b_ovf_evt;
  logic [NUM_A-1:0] a_s1, a_s2, a_s3, a_lvl, a_lvl_d, a_rise;
  logic [NUM_B-1:0] b_s1, b_s2, b_s3, b_lvl, b_lvl_d, b_rise, b_any;
  logic n_s1, n_s2, n_s3, nmi_lvl;
  logic [NUM_CH-1:0] irq_flag, irq_clr;
  logic [7:0] a_mode [NUM_A];
  logic [15:0] a_cnt [NUM_A];
  logic [15:0] a_rel [NUM_A];
  logic [15:0] a_rd [NUM_A];
  os_state_t os [NUM_A];
  logic [7:0] b_mode [NUM_B];
  logic [15:0] b_cnt [NUM_B];
  logic [15:0] b_rel [NUM_B];
  logic [15:0] b_rd [NUM_B];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Write channel: address and data may arrive in either order
  assign awready = !aw_held;
  assign wready = !w_held;
  assign wr_fire = aw_held && w_held && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wa <= 8'h00;
      wd <= 32'h0000_0000;
      ws <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wa <= awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wd <= wdata;
        ws <= wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_comb begin
    case (wa[7:5])
      3'h0: wr_ok = wa[4:0] <= DIRECTION_OFS[4:0];
      A_MODE_BASE[7:5], A_CNT_BASE[7:5]: wr_ok = 32'(wa[4:2]) < NUM_A;
      B_MODE_BASE[7:5], B_CNT_BASE[7:5]: wr_ok = 32'(wa[4:2]) < NUM_B;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel: one word answered per accepted address
  assign arready = !rvalid;
  assign rd_fire = arvalid && arready;

  always_comb begin
    rd_val = CNT_RESET;
    rd_ok = 1'b1;
    case (araddr[7:5])
      3'h0: begin
        case (araddr[4:0])
          START_ONE_OFS[4:0]: rd_val = {8'h00, start_one};
          START_TWO_OFS[4:0]: rd_val = {8'h00, start_two};
          SPECIAL_OFS[4:0]: rd_val = 16'(cutoff_enable);
          IRQ_FLAG_OFS[4:0]: rd_val = 16'(irq_flag);
          SW_TRIG_OFS[4:0]: rd_val = CNT_RESET;
          DIRECTION_OFS[4:0]: rd_val = 16'(a_dir);
          default: rd_ok = 1'b0;
        endcase
      end
      A_MODE_BASE[7:5], A_CNT_BASE[7:5]: begin
        rd_ok = 32'(araddr[4:2]) < NUM_A;
        if (rd_ok) begin
          rd_val = araddr[5] ? a_rd[araddr[4:2]] : {8'h00, a_mode[araddr[4:2]]};
        end
      end
      B_MODE_BASE[7:5], B_CNT_BASE[7:5]: begin
        rd_ok = 32'(araddr[4:2]) < NUM_B;
        if (rd_ok) begin
          rd_val = araddr[5] ? b_rd[araddr[4:2]]
                 : {8'h00, b_mode[araddr[4:2]] | (8'(b_ovf[araddr[4:2]]) << OVF_BIT)};
        end
      end
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid <= 1'b1;
      rdata <= {16'h0000, rd_val};
      rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Common registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_one <= 8'h00;
      start_two <= 8'h00;
      cutoff_enable <= 1'b0;
      a_dir <= '0;
    end else if (wr_fire && ws[0]) begin
      if (wa == START_ONE_OFS) start_one <= wd[7:0]; // RULE1
      if (wa == START_TWO_OFS) start_two <= wd[7:0] & START_TWO_MASK;
      if (wa == SPECIAL_OFS) cutoff_enable <= wd[CUTOFF_BIT];
      if (wa == DIRECTION_OFS) a_dir <= wd[NUM_A-1:0];
    end
  end

  assign sw_trig = (wr_fire && ws[0] && wa == SW_TRIG_OFS) ? wd[NUM_A-1:0] : '0;
  assign irq_clr = (wr_fire && wa == IRQ_FLAG_OFS) ? NUM_CH'(merge16(16'h0000, wd, ws)) : '0;

  // A new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_flag <= '0;
    else irq_flag <= (irq_flag & ~irq_clr) | {b_set, a_set};
  end
  assign group_a_int_request = irq_flag[NUM_A-1:0];
  assign group_b_int_request = irq_flag[NUM_CH-1:NUM_A];

  // Pin inputs: three stages, a level counts once stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {a_s1, a_s2, a_s3, a_lvl, a_lvl_d} <= '0;
      {b_s1, b_s2, b_s3, b_lvl, b_lvl_d} <= '0;
      {n_s1, n_s2, n_s3, nmi_lvl} <= 4'hF;
      pre <= 8'h00;
      a_run_d <= '0;
      b_run_d <= '0;
    end else begin
      a_s1 <= group_a_trigger_pin;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      a_lvl <= (a_lvl & (a_s2 ^ a_s3)) | (a_s3 & ~(a_s2 ^ a_s3));
      a_lvl_d <= a_lvl;
      b_s1 <= group_b_input_pin;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
      b_lvl <= (b_lvl & (b_s2 ^ b_s3)) | (b_s3 & ~(b_s2 ^ b_s3));
      b_lvl_d <= b_lvl;
      n_s1 <= nmi_n;
      n_s2 <= n_s1;
      n_s3 <= n_s2;
      if (n_s2 == n_s3) nmi_lvl <= n_s3;
      pre <= pre + 8'h01;
      a_run_d <= a_run;
      b_run_d <= b_run;
    end
  end
  assign a_rise = a_lvl & ~a_lvl_d;
  assign b_rise = b_lvl & ~b_lvl_d;
  assign b_any = b_lvl ^ b_lvl_d;
  assign cutoff = cutoff_enable && !nmi_lvl;
  assign group_a_output_pin = a_out_q;

  for (genvar i = 0; i < NUM_A; i++) begin : g_a
    logic tick, ev, up, wr_mode, wr_cnt, trig, pend, stop_now, stop_d, os_done, pwm_fall;
    logic mode_irq;
    logic [7:0] new_mode;
    a_mode_t m;
    assign m = a_mode_t'(a_mode[i][MODE_LSB +: 2]);
    assign a_run[i] = start_one[i];
    assign tick = (pre & src_mask(a_mode[i][SRC_LSB +: 2])) == 8'h00;
    assign ev = a_rise[i];
    assign up = a_dir[i];
    assign trig = a_mode[i][FN1_BIT] ? a_rise[i] : sw_trig[i];
    assign wr_mode = wr_fire && wa == A_MODE_BASE + 8'(4 * i);
    assign wr_cnt = wr_fire && wa == A_CNT_BASE + 8'(4 * i);
    assign new_mode = ws[0] ? wd[7:0] : a_mode[i];
    assign stop_now = a_run_d[i] && !a_run[i];
    assign a_reload_now[i] = a_run[i] && a_cnt[i] == CNT_RESET
                          && ((m == A_TIMER && tick) || (m == A_EVENT && ev && !up));
    assign a_ovf_now[i] = a_run[i] && m == A_EVENT && ev && up && a_cnt[i] == CNT_FULL;
    assign os_done = a_run[i] && m == A_ONESHOT && os[i] == OS_RUN && tick
                  && a_cnt[i] <= 16'h0001;
    assign pwm_fall = a_run[i] && m == A_PWM && tick && a_cnt[i] == CNT_RESET && a_out_q[i];
    assign mode_irq = wr_mode && new_mode[MODE_LSB + 1] && !m[1]; // RULE9 RULE13
    assign a_set[i] = a_reload_now[i] || a_ovf_now[i] || os_done || pwm_fall || stop_d
                   || (stop_now && m == A_PWM && a_out_q[i]) || mode_irq; // RULE14
    assign a_rd[i] = !a_run[i] ? a_rel[i] // RULE4
                   : a_reload_now[i] ? CNT_FULL // RULE3 RULE6
                   : a_ovf_now[i] ? CNT_RESET : a_cnt[i]; // RULE6
    // Floating the pin is the only action; counting carries on during cutoff
    assign group_a_output_oe_n[i] = !a_mode[i][FN0_BIT] || (cutoff && CUTOFF_CHANNELS[i]); // RULE5

    always_ff @(posedge aclk) begin
      if (!aresetn) a_mode[i] <= MODE_RESET;
      else if (wr_mode) a_mode[i] <= new_mode;
    end

    // One-shot stop raises its flag one clock after the stop is seen
    always_ff @(posedge aclk) begin
      if (!aresetn) stop_d <= 1'b0;
      else stop_d <= stop_now && m == A_ONESHOT; // RULE7
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        a_cnt[i] <= CNT_RESET;
        a_rel[i] <= CNT_RESET;
        a_out_q[i] <= 1'b0;
        os[i] <= OS_IDLE;
        pend <= 1'b0;
      end else begin
        if (wr_cnt) a_rel[i] <= merge16(a_rel[i], wd, ws); // RULE23
        if (!a_run[i]) begin
          pend <= 1'b0;
          os[i] <= OS_IDLE;
          if (wr_cnt) a_cnt[i] <= merge16(a_rel[i], wd, ws); // RULE4
          if (stop_now && m == A_ONESHOT) a_cnt[i] <= a_rel[i]; // RULE7
          if (stop_now && m != A_TIMER && m != A_EVENT) a_out_q[i] <= 1'b0; // RULE7 RULE14
        end else if (!a_run_d[i] && m == A_PWM) begin
          a_cnt[i] <= a_rel[i];
          a_out_q[i] <= a_rel[i] != CNT_RESET;
        end else begin
          case (m)
            A_TIMER: if (tick) a_cnt[i] <= a_reload_now[i] ? a_rel[i] : a_cnt[i] - 16'h0001;
            A_EVENT: begin
              if (a_reload_now[i] || a_ovf_now[i]) a_cnt[i] <= a_rel[i];
              else if (ev) a_cnt[i] <= up ? a_cnt[i] + 16'h0001 : a_cnt[i] - 16'h0001;
            end
            A_ONESHOT: begin
              // Output moves only on a tick, so a trigger waits at most one tick
              if (trig) pend <= 1'b1; // RULE8
              case (os[i])
                OS_IDLE: if (tick && (pend || trig)) begin
                  os[i] <= OS_RUN;
                  a_cnt[i] <= a_rel[i];
                  a_out_q[i] <= 1'b1; // RULE8
                  pend <= 1'b0;
                end
                OS_RUN: begin
                  if (os_done) begin
                    os[i] <= OS_IDLE;
                    a_cnt[i] <= a_rel[i];
                    a_out_q[i] <= 1'b0;
                  end else if (tick) a_cnt[i] <= a_cnt[i] - 16'h0001;
                  if (trig && !os_done) os[i] <= OS_RETRIG; // RULE10
                  if (trig) pend <= 1'b0;
                end
                OS_RETRIG: if (tick) begin
                  // This tick is the one extra count; the reload restarts the shot
                  a_cnt[i] <= a_rel[i]; // RULE10
                  os[i] <= OS_RUN;
                  pend <= 1'b0;
                end
                default: os[i] <= OS_IDLE;
              endcase
            end
            default: if (tick) begin
              if (a_cnt[i] == CNT_RESET) begin
                a_out_q[i] <= !a_out_q[i];
                a_cnt[i] <= a_out_q[i] ? ~a_rel[i] : a_rel[i];
              end else a_cnt[i] <= a_cnt[i] - 16'h0001;
            end
          endcase
        end
      end
    end

    a_idle_stopped: assert property (!a_run[i] && !a_run_d[i] && !wr_cnt // RULE1
      |=> $stable(a_cnt[i]) && $stable(a_out_q[i]))
      else $error("stopped group A counter moved");
  end

  for (genvar j = 0; j < NUM_B; j++) begin : g_b
    logic tick, eff, wr_mode, wr_cnt, ticked;
    b_mode_t m;
    assign m = b_mode_t'(b_mode[j][MODE_LSB +: 2]);
    if (j < 3) begin : g_one
      assign b_run[j] = start_one[B_START_LSB + j]; // RULE15
    end else begin : g_two
      assign b_run[j] = start_two[B_START_LSB + j - 3]; // RULE15
    end
    assign tick = (pre & src_mask(b_mode[j][SRC_LSB +: 2])) == 8'h00;
    assign eff = b_mode[j][FN0_BIT] ? b_any[j] : b_rise[j]; // RULE22
    assign wr_mode = wr_fire && wa == B_MODE_BASE + 8'(4 * j);
    assign wr_cnt = wr_fire && wa == B_CNT_BASE + 8'(4 * j);
    assign b_reload_now[j] = b_run[j] && b_cnt[j] == CNT_RESET
                          && ((m == B_TIMER && tick) || (m == B_EVENT && b_rise[j]));
    assign b_ovf_evt[j] = b_run[j] && m == B_MEASURE && tick && !eff && b_cnt[j] == CNT_FULL;
    assign b_set[j] = b_reload_now[j] || b_ovf_evt[j] // RULE17 RULE21
                   || (b_run[j] && m == B_MEASURE && eff && b_seen[j]); // RULE20
    assign b_rd[j] = !b_run[j] ? b_rel[j] : b_reload_now[j] ? CNT_FULL // RULE16
                   : m == B_MEASURE ? b_rel[j] : b_cnt[j];

    always_ff @(posedge aclk) begin
      if (!aresetn) b_mode[j] <= MODE_RESET;
      else if (wr_mode) b_mode[j] <= (ws[0] ? wd[7:0] : b_mode[j]) & B_MODE_STORE_MASK;
    end

    // Clearing needs a tick after setting, so a late edge is not mistaken for overflow
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        b_ovf[j] <= 1'b0;
        ticked <= 1'b0;
      end else if (b_ovf_evt[j]) begin
        b_ovf[j] <= 1'b1; // RULE17
        ticked <= 1'b0;
      end else begin
        if (tick) ticked <= 1'b1;
        if (wr_mode && b_run[j] && ticked && ws[0] && !wd[OVF_BIT]) b_ovf[j] <= 1'b0; // RULE18
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        b_cnt[j] <= CNT_RESET;
        b_rel[j] <= CNT_RESET;
        b_seen[j] <= 1'b0;
      end else begin
        if (wr_cnt) b_rel[j] <= merge16(b_rel[j], wd, ws); // RULE23
        if (!b_run[j]) begin
          b_seen[j] <= 1'b0;
          if (wr_cnt) b_cnt[j] <= merge16(b_rel[j], wd, ws); // RULE4
        end else begin
          case (m)
            B_TIMER: if (tick) b_cnt[j] <= b_reload_now[j] ? b_rel[j] : b_cnt[j] - 16'h0001;
            B_EVENT: if (b_rise[j]) begin
              b_cnt[j] <= b_reload_now[j] ? b_rel[j] : b_cnt[j] - 16'h0001;
            end
            B_MEASURE: begin
              // Counter is left as found at start, so the first capture is meaningless
              if (eff) begin
                b_rel[j] <= b_cnt[j]; // RULE20 RULE22
                b_cnt[j] <= CNT_RESET;
                b_seen[j] <= 1'b1;
              end else if (tick) b_cnt[j] <= b_cnt[j] + 16'h0001; // RULE21
            end
            default: b_cnt[j] <= b_cnt[j];
          endcase
        end
      end
    end
  end

  sequence os_stop_s;
    a_run_d[0] && !a_run[0] && a_mode[0][1:0] == A_ONESHOT;
  endsequence
  sequence os_stop_effect_s;
    !a_out_q[0] && a_cnt[0] == $past(a_rel[0]) ##1 irq_flag[0];
  endsequence

  a_timer_reload_read: assert property (rd_fire && araddr == A_CNT_BASE // RULE3
    && a_mode[0][1:0] == A_TIMER && a_reload_now[0] |=> rdata == {16'h0000, CNT_FULL})
    else $error("timer reload read not FFFFh");
  a_stopped_read: assert property (rd_fire && araddr == A_CNT_BASE && !a_run[0] // RULE4
    && !wr_fire |=> rdata[15:0] == $past(a_rel[0]))
    else $error("stopped read not the written value");
  a_cutoff_float: assert property (cutoff_enable && !nmi_lvl |-> // RULE5
    group_a_output_oe_n[1] && group_a_output_oe_n[2] && group_a_output_oe_n[4])
    else $error("cutoff did not float outputs");
  a_event_ovf_read: assert property (rd_fire && araddr == A_CNT_BASE && a_ovf_now[0] // RULE6
    |=> rdata == 32'h0000_0000)
    else $error("event overflow read not 0000h");
  a_oneshot_stop: assert property (os_stop_s |=> os_stop_effect_s) // RULE7
    else $error("one-shot stop sequence wrong");
  a_mode_entry_irq: assert property (wr_fire && wa == A_MODE_BASE && ws[0] // RULE9
    && wd[1] && !a_mode[0][1] |=> irq_flag[0])
    else $error("mode entry did not raise request");
  a_pwm_stop: assert property (a_run_d[0] && !a_run[0] && a_mode[0][1:0] == A_PWM // RULE14
    |=> !a_out_q[0] && (irq_flag[0] || !$past(a_out_q[0])))
    else $error("pwm stop wrong");
  a_b_start_map: assert property (b_run[0] == start_one[5] && b_run[3] == start_two[5]) // RULE15
    else $error("group B start bit map wrong");
  a_b_reload_read: assert property (rd_fire && araddr == B_CNT_BASE // RULE16
    && b_reload_now[0] |=> rdata[15:0] == CNT_FULL)
    else $error("group B reload read not FFFFh");
  a_ovf_clear_cause: assert property ($fell(b_ovf[0]) |-> $past(b_run[0]) // RULE18
    && $past(wr_fire && wa == B_MODE_BASE))
    else $error("overflow bit cleared without mode write");
  a_first_edge_quiet: assert property (b_run[0] && !b_seen[0] && !b_ovf_evt[0] // RULE20
    && b_mode[0][1:0] == B_MEASURE |-> !b_set[0])
    else $error("first measured edge raised request");
endmodule : multi_mode_timer_unit

// >>> rtl/timer_unit_pkg.sv
// Constants, register map and types for the multi-mode timer unit
// Operation
// [RULE1] Channels stay idle after reset until software sets the start bit.
// [RULE2] Software changes mode and trigger settings only while the start bit is 0.
// [RULE3] Group A timer mode: a read coinciding with a reload returns FFFFh.
// [RULE4] Reads of a stopped, written counter return the written value.
// [RULE5] Cutoff enabled and interrupt pin low: outputs of channels 1, 2, 4 float.
// [RULE6] Group A event mode: underflow or reload reads FFFFh, overflow reads 0000h.
// [RULE7] One-shot stop: reload, output low, request flag set one clock later.
// [RULE8] One-shot output follows count source ticks, trigger delay at most one tick.
// [RULE9] Entering one-shot from timer or event mode sets the request flag.
// [RULE10] One-shot retrigger while counting: count once more, reload, continue.
// [RULE11] Retriggers must come more than one count source cycle apart.
// [RULE12] No external trigger within 300 ns before the counter reaches 0000h.
// [RULE13] Entering PWM from timer or event mode sets the request flag.
// [RULE14] PWM stop: high output goes low and sets the flag; low output unchanged.
// [RULE15] Group B start bits: channels 0-2 and 3-5 at bits 5-7 of two registers.
// [RULE16] Group B timer mode: a read during a reload returns FFFFh.
// [RULE17] Measurement: flag set on effective edge or overflow; overflow bit tells which.
// [RULE18] Overflow bit cleared only by a running mode write after a further tick.
// [RULE19] That clearing write repeats the mode fields and writes the reserved bit 0.
// [RULE20] First measured edge after start loads the reload register, no request.
// [RULE21] Measurement counter starts undefined; overflow may occur before first edge.
// [RULE22] Width measurement reports high and low widths back to back, unlabelled.
// [RULE23] Counters and reloads are 16 bits; a stopped counter access hits the reload.
package timer_unit_pkg;
  localparam logic [7:0] START_ONE_OFS = 8'h00;
  localparam logic [7:0] START_TWO_OFS = 8'h04;
  localparam logic [7:0] SPECIAL_OFS = 8'h08;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h0C;
  localparam logic [7:0] SW_TRIG_OFS = 8'h10;
  localparam logic [7:0] DIRECTION_OFS = 8'h14;
  localparam logic [7:0] A_MODE_BASE = 8'h40;
  localparam logic [7:0] A_CNT_BASE = 8'h60;
  localparam logic [7:0] B_MODE_BASE = 8'h80;
  localparam logic [7:0] B_CNT_BASE = 8'hA0;
  localparam int MODE_LSB = 0;
  localparam int FN0_BIT = 2;
  localparam int FN1_BIT = 3;
  localparam int RSV_BIT = 4;
  localparam int OVF_BIT = 5;
  localparam int SRC_LSB = 6;
  localparam int B_START_LSB = 5;
  localparam int CUTOFF_BIT = 0;
  localparam logic [7:0] CUTOFF_CHANNELS = 8'h16;
  localparam logic [7:0] START_TWO_MASK = 8'hE0;
  localparam logic [7:0] B_MODE_STORE_MASK = 8'hCF;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] CNT_FULL = 16'hFFFF;
  localparam logic [7:0] PRE_MASK_DIV8 = 8'h07;
  localparam logic [7:0] PRE_MASK_DIV32 = 8'h1F;
  localparam logic [7:0] PRE_MASK_DIV256 = 8'hFF;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {A_TIMER = 2'b00, A_EVENT = 2'b01, A_ONESHOT = 2'b10,
                            A_PWM = 2'b11} a_mode_t;
  typedef enum logic [1:0] {B_TIMER = 2'b00, B_EVENT = 2'b01, B_MEASURE = 2'b10,
                            B_UNUSED = 2'b11} b_mode_t;
  typedef enum logic [2:0] {OS_IDLE = 3'b001, OS_RUN = 3'b010, OS_RETRIG = 3'b100} os_state_t;
endpackage : timer_unit_pkg

// >>> test/pin_partner.sv
// Pin source model for the timer unit trigger and measured inputs
module pin_partner (
  input wire logic aclk, // Clock
  input wire logic [4:0] a_req, // Trigger levels wanted
  output logic [4:0] a_pin, // Group A trigger pins
  output logic [5:0] b_pin // Group B input pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    a_pin = 5'h00;
    b_pin = 6'h00;
  end
  // Levels move only on an edge, so no pulse is shorter than a whole clock
  always @(posedge aclk) begin
    a_pin <= a_req;
    b_pin <= 6'h00;
  end
endmodule : pin_partner

// >>> test/tb.sv
// Self-checking bench for the multi-mode timer unit
module tb import timer_unit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, nmi_n = 1'b1, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp, rs;
  logic [4:0] a_req = 5'h00, a_pin, a_out, a_oe_n, a_irq;
  logic [5:0] b_pin, b_irq;
  int failures = 0, samples_checked = 0, cycles = 0;
  always #25 aclk = ~aclk;
  multi_mode_timer_unit dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .group_a_trigger_pin(a_pin), .group_b_input_pin(b_pin), .nmi_n,
    .group_a_output_pin(a_out), .group_a_output_oe_n(a_oe_n), .group_a_int_request(a_irq),
    .group_b_int_request(b_irq));
  pin_partner pp_u (.aclk, .a_req, .a_pin, .b_pin);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Ready is looked at before the edge, so a flop launched on that edge cannot race it
    fork
      begin
        do @(negedge aclk); while (awready !== 1'b1);
        @(posedge aclk);
        awvalid <= 1'b0;
      end
      begin
        do @(negedge aclk); while (wready !== 1'b1);
        @(posedge aclk);
        wvalid <= 1'b0;
      end
    join
    do @(negedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd_reg
  task automatic t_idle;
    rd_reg(A_CNT_BASE);
    chk("a0 count", 32'h0000_0000, rd);
    wr(A_CNT_BASE, 32'h0000_1234);
    repeat (20) @(posedge aclk);
    rd_reg(A_CNT_BASE);
    chk("a0 written", 32'h0000_1234, rd);
    rd_reg(8'hFC);
    chk("unmapped resp", 32'h0000_0002, {30'h0, rs});
    $display("test idle done");
  endtask : t_idle
  task automatic t_start_b;
    wr(START_TWO_OFS, 32'h0000_00FF);
    rd_reg(START_TWO_OFS);
    chk("start two", 32'h0000_00E0, rd);
    wr(START_ONE_OFS, 32'h0000_00E0);
    rd_reg(START_ONE_OFS);
    chk("start one", 32'h0000_00E0, rd);
    rd_reg(B_CNT_BASE);
    chk("b0 reload read", 32'h0000_FFFF, rd);
    wr(START_ONE_OFS, 32'h0000_0000);
    wr(START_TWO_OFS, 32'h0000_0000);
    $display("test start bits done");
  endtask : t_start_b
  task automatic t_cutoff;
    wr(A_MODE_BASE, 32'h0000_0004);
    wr(A_MODE_BASE + 8'h04, 32'h0000_0004);
    wr(SPECIAL_OFS, 32'h0000_0001);
    nmi_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("oe_n cut", 32'h0000_0002, {30'h0, a_oe_n[1:0]});
    nmi_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("oe_n free", 32'h0000_0000, {30'h0, a_oe_n[1:0]});
    $display("test cutoff done");
  endtask : t_cutoff
  task automatic t_oneshot;
    wr(IRQ_FLAG_OFS, 32'h0000_07FF);
    wr(A_CNT_BASE, 32'h0000_0100);
    wr(A_MODE_BASE, 32'h0000_0006);
    wr(A_MODE_BASE + 8'h04, 32'h0000_0007);
    rd_reg(IRQ_FLAG_OFS);
    chk("entry flags", 32'h0000_0003, {30'h0, rd[1:0]});
    wr(IRQ_FLAG_OFS, 32'h0000_0001);
    wr(START_ONE_OFS, 32'h0000_0001);
    wr(SW_TRIG_OFS, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    chk("shot out", 32'h0000_0001, {31'h0, a_out[0]});
    wr(START_ONE_OFS, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    chk("stop out", 32'h0000_0000, {31'h0, a_out[0]});
    rd_reg(IRQ_FLAG_OFS);
    chk("stop flag", 32'h0000_0001, {31'h0, rd[0]});
    rd_reg(A_CNT_BASE);
    chk("stop reload", 32'h0000_0100, rd);
    wr(A_MODE_BASE, 32'h0000_000E);
    wr(START_ONE_OFS, 32'h0000_0001);
    a_req <= 5'h01;
    repeat (8) @(posedge aclk);
    chk("pin shot out", 32'h0000_0001, {31'h0, a_out[0]});
    a_req <= 5'h00;
    wr(START_ONE_OFS, 32'h0000_0000);
    $display("test one-shot done");
  endtask : t_oneshot
  task automatic t_measure;
    wr(B_MODE_BASE, 32'h0000_0002);
    wr(B_CNT_BASE, 32'h0000_FFF0);
    wr(START_ONE_OFS, 32'h0000_0020);
    repeat (30) @(posedge aclk);
    rd_reg(B_MODE_BASE);
    chk("b0 ovf bit", 32'h0000_0001, {31'h0, rd[OVF_BIT]});
    chk("b0 request", 32'h0000_0001, {31'h0, b_irq[0]});
    wr(B_MODE_BASE, 32'h0000_0002);
    rd_reg(B_MODE_BASE);
    chk("b0 ovf clear", 32'h0000_0000, {31'h0, rd[OVF_BIT]});
    wr(START_ONE_OFS, 32'h0000_0000);
    $display("test measure done");
  endtask : t_measure
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // Whole run needs a few hundred cycles; the ceiling leaves wide margin
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_idle();
    t_start_b();
    t_cutoff();
    t_oneshot();
    t_measure();
    final_report();
  end
endmodule : tb
